/* hw/iopd_pkg.sv */
package iopd_pkg;
  localparam logic [4:0] ADR_PORT_A = 5'h00;
  localparam logic [4:0] ADR_PORT_B = 5'h01;
  localparam logic [4:0] ADR_PORT_C = 5'h02;
  localparam logic [4:0] ADR_PORT_D = 5'h03;
  localparam logic [4:0] ADR_EXT_LO = 5'h04;
  localparam logic [4:0] ADR_EXT_HI = 5'h0f;
  localparam logic [4:0] ADR_IFR_CLR = 5'h10;
  localparam logic [4:0] ADR_IFR = 5'h11;
  localparam logic [4:0] ADR_IER = 5'h12;
  localparam logic [4:0] ADR_MODE = 5'h14;
  localparam logic [4:0] ADR_SCTL = 5'h15;
  localparam logic [4:0] ADR_SSTAT = 5'h16;
  localparam logic [4:0] ADR_SDATA = 5'h17;
  localparam logic [4:0] ADR_A_LLO = 5'h18;
  localparam logic [4:0] ADR_A_LHI = 5'h19;
  localparam logic [4:0] ADR_A_LOAD = 5'h1a;
  localparam logic [4:0] ADR_A_LO = 5'h1b;
  localparam logic [4:0] ADR_B_LLO = 5'h1c;
  localparam logic [4:0] ADR_B_COPY = 5'h1d;
  localparam logic [4:0] ADR_B_LOAD = 5'h1e;
  localparam logic [4:0] ADR_B_LO = 5'h1f;
  // read-side aliases of the counter addresses
  localparam logic [4:0] ADR_A_LO_CLR = 5'h19;
  localparam logic [4:0] ADR_A_HI = 5'h1a;
  localparam logic [4:0] ADR_B_LO_CLR = 5'h1d;
  localparam logic [4:0] ADR_B_HI = 5'h1e;
  localparam logic [7:0] READ_FILL = 8'hff;
  localparam logic [7:0] SSTAT_RST = 8'h80;
  localparam logic [7:0] SSTAT_WMASK = 8'h30;
  localparam logic [7:0] IFR_CLR_MASK = 8'h0f;
  localparam int SSTAT_RX_FULL = 0;
  localparam int SSTAT_TX_EMPTY = 7;
  localparam int IFR_UF_A = 4;
  localparam int IFR_UF_B = 5;
  localparam int IFR_RX = 6;
  localparam int IFR_TX = 7;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } iopd_req_s;

  typedef struct packed {
    logic [7:0] port_a, port_b, port_c, port_d;
    logic [7:0] mode, sctl, sstat, rxd, txd, ier, ifr;
    logic [15:0] latch_a, latch_b, latch_c, cnt_a, cnt_b;
    logic [7:0] rdata;
    logic rvalid;
    logic ext_rd, ext_wr, ext_pend;
    logic [4:0] ext_addr;
    logic [7:0] ext_wdata;
    logic tx_load;
  } iopd_state_s;
endpackage

/* hw/iopd_io_page.sv */
`timescale 1ns/1ns
// Operation
// - 0x17 reads rx char, writes tx holding
// - 0x16 reads status, writes bits 4,5 only
// - 0x15 serial control, 0x14 mode, read/write
// - counter B load: upper latch, reload, clear
// - counter B copy: upper latch, latch C
// - counter B low read, clearing or plain
// - counter A load: upper latch, reload, clear
// - counter A low read, clearing or plain
// - flag clear: zeros clear bits 0-3
// - 0x04-0x0F forwarded to external bus
module iopd_io_page (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire iopd_pkg::iopd_req_s BUS_REQ_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  output logic EXT_RD_O,
  output logic EXT_WR_O,
  output logic [4:0] EXT_ADDR_O,
  output logic [7:0] EXT_WDATA_O,
  input wire logic [7:0] EXT_RDATA_I,
  input wire logic [3:0] EDGE_FLAG_I,
  input wire logic SER_RX_STB_I,
  input wire logic [7:0] SER_RX_DATA_I,
  input wire logic SER_TX_DONE_I,
  output logic [7:0] SER_TXD_O,
  output logic SER_TX_LOAD_O,
  output logic [31:0] PORTS_O,
  output logic [7:0] MODE_O,
  output logic [7:0] SCTL_O,
  output logic [7:0] IER_O,
  output logic [7:0] IFR_O,
  output logic [15:0] LATCH_C_O
);
  function automatic logic is_ext(input logic [4:0] a);
    return a >= iopd_pkg::ADR_EXT_LO && a <= iopd_pkg::ADR_EXT_HI;
  endfunction

  iopd_pkg::iopd_state_s q, d;
  logic rd, wr, uf_a, uf_b;
  logic [7:0] set_f, clr_f, wd;
  logic [4:0] ad;

  assign rd = BUS_REQ_I.rd;
  assign wr = BUS_REQ_I.wr;
  assign ad = BUS_REQ_I.addr;
  assign wd = BUS_REQ_I.wdata;

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.ext_rd = 1'b0;
    d.ext_wr = 1'b0;
    d.ext_pend = 1'b0;
    d.tx_load = 1'b0;
    clr_f = 8'h00;
    // free-running down counters, reload from latch on underflow
    uf_a = (q.cnt_a == 16'h0000);
    uf_b = (q.cnt_b == 16'h0000);
    d.cnt_a = uf_a ? q.latch_a : q.cnt_a - 16'h0001;
    d.cnt_b = uf_b ? q.latch_b : q.cnt_b - 16'h0001;
    if (q.ext_pend) begin
      d.rdata = EXT_RDATA_I;
      d.rvalid = 1'b1;
    end
    if (rd && is_ext(ad)) begin
      d.ext_rd = 1'b1;
      d.ext_pend = 1'b1;
      d.ext_addr = ad;
    end else if (rd) begin
      d.rvalid = 1'b1;
      unique case (ad)
        iopd_pkg::ADR_PORT_A: d.rdata = q.port_a;
        iopd_pkg::ADR_PORT_B: d.rdata = q.port_b;
        iopd_pkg::ADR_PORT_C: d.rdata = q.port_c;
        iopd_pkg::ADR_PORT_D: d.rdata = q.port_d;
        iopd_pkg::ADR_IFR: d.rdata = q.ifr;
        iopd_pkg::ADR_IER: d.rdata = q.ier;
        iopd_pkg::ADR_MODE: d.rdata = q.mode;
        iopd_pkg::ADR_SCTL: d.rdata = q.sctl;
        iopd_pkg::ADR_SSTAT: d.rdata = q.sstat;
        iopd_pkg::ADR_SDATA: begin
          d.rdata = q.rxd;
          d.sstat[iopd_pkg::SSTAT_RX_FULL] = 1'b0;
          clr_f[iopd_pkg::IFR_RX] = 1'b1;
        end
        iopd_pkg::ADR_A_LO: d.rdata = q.cnt_a[7:0];
        iopd_pkg::ADR_A_HI: d.rdata = q.cnt_a[15:8];
        iopd_pkg::ADR_A_LO_CLR: begin
          d.rdata = q.cnt_a[7:0];
          clr_f[iopd_pkg::IFR_UF_A] = 1'b1;
        end
        iopd_pkg::ADR_B_LO: d.rdata = q.cnt_b[7:0];
        iopd_pkg::ADR_B_HI: d.rdata = q.cnt_b[15:8];
        iopd_pkg::ADR_B_LO_CLR: begin
          d.rdata = q.cnt_b[7:0];
          clr_f[iopd_pkg::IFR_UF_B] = 1'b1;
        end
        default: d.rdata = iopd_pkg::READ_FILL;
      endcase
    end
    if (wr && is_ext(ad)) begin
      d.ext_wr = 1'b1;
      d.ext_addr = ad;
      d.ext_wdata = wd;
    end else if (wr) begin
      unique case (ad)
        iopd_pkg::ADR_PORT_A: d.port_a = wd;
        iopd_pkg::ADR_PORT_B: d.port_b = wd;
        iopd_pkg::ADR_PORT_C: d.port_c = wd;
        iopd_pkg::ADR_PORT_D: d.port_d = wd;
        iopd_pkg::ADR_IFR_CLR: clr_f = ~wd & iopd_pkg::IFR_CLR_MASK;
        iopd_pkg::ADR_IER: d.ier = wd;
        iopd_pkg::ADR_MODE: d.mode = wd;
        iopd_pkg::ADR_SCTL: d.sctl = wd;
        iopd_pkg::ADR_SSTAT: d.sstat = (q.sstat & ~iopd_pkg::SSTAT_WMASK)
            | (wd & iopd_pkg::SSTAT_WMASK);
        iopd_pkg::ADR_SDATA: begin
          d.txd = wd;
          d.tx_load = 1'b1;
          d.sstat[iopd_pkg::SSTAT_TX_EMPTY] = 1'b0;
          clr_f[iopd_pkg::IFR_TX] = 1'b1;
        end
        iopd_pkg::ADR_A_LLO: d.latch_a[7:0] = wd;
        iopd_pkg::ADR_A_LHI: d.latch_a[15:8] = wd;
        iopd_pkg::ADR_A_LOAD: begin
          d.latch_a[15:8] = wd;
          d.cnt_a = {wd, q.latch_a[7:0]};
          clr_f[iopd_pkg::IFR_UF_A] = 1'b1;
        end
        iopd_pkg::ADR_B_LLO: d.latch_b[7:0] = wd;
        iopd_pkg::ADR_B_COPY: begin
          d.latch_b[15:8] = wd;
          d.latch_c = {wd, q.latch_b[7:0]};
        end
        iopd_pkg::ADR_B_LOAD: begin
          d.latch_b[15:8] = wd;
          d.cnt_b = {wd, q.latch_b[7:0]};
          clr_f[iopd_pkg::IFR_UF_B] = 1'b1;
        end
        default: ;
      endcase
    end
    // hardware events win over a clear in the same cycle
    if (SER_RX_STB_I) begin
      d.rxd = SER_RX_DATA_I;
      d.sstat[iopd_pkg::SSTAT_RX_FULL] = 1'b1;
    end
    if (SER_TX_DONE_I) begin
      d.sstat[iopd_pkg::SSTAT_TX_EMPTY] = 1'b1;
    end
    set_f = {SER_TX_DONE_I, SER_RX_STB_I, uf_b, uf_a, EDGE_FLAG_I};
    d.ifr = (q.ifr & ~clr_f) | set_f;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      q <= '0;
      q.sstat <= iopd_pkg::SSTAT_RST;
    end else begin
      q <= d;
    end
  end

  assign RDATA_O = q.rdata;
  assign RVALID_O = q.rvalid;
  assign EXT_RD_O = q.ext_rd;
  assign EXT_WR_O = q.ext_wr;
  assign EXT_ADDR_O = q.ext_addr;
  assign EXT_WDATA_O = q.ext_wdata;
  assign SER_TXD_O = q.txd;
  assign SER_TX_LOAD_O = q.tx_load;
  assign PORTS_O = {q.port_d, q.port_c, q.port_b, q.port_a};
  assign MODE_O = q.mode;
  assign SCTL_O = q.sctl;
  assign IER_O = q.ier;
  assign IFR_O = q.ifr;
  assign LATCH_C_O = q.latch_c;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_rx_read: assert property (
    rd && ad == iopd_pkg::ADR_SDATA && !SER_RX_STB_I
    |=> RVALID_O && RDATA_O == $past(q.rxd)) else $error("rx read bad");
  a_stat_write: assert property (
    wr && ad == iopd_pkg::ADR_SSTAT && !SER_RX_STB_I && !SER_TX_DONE_I
    |=> q.sstat == (($past(q.sstat) & 8'hcf) | ($past(wd) & 8'h30)))
    else $error("status write bad");
  a_mode_rw: assert property (
    wr && ad == iopd_pkg::ADR_MODE ##1 !wr ##1 rd && ad == iopd_pkg::ADR_MODE
    |=> RDATA_O == $past(wd, 3)) else $error("mode readback bad");
  // an underflow in the load cycle still sets the flag: set beats clear
  a_b_load: assert property (
    wr && ad == iopd_pkg::ADR_B_LOAD && q.cnt_b != 16'h0000
    |=> q.cnt_b == {$past(wd), $past(q.latch_b[7:0])}
        && !q.ifr[iopd_pkg::IFR_UF_B]) else $error("counter b load bad");
  a_b_copy: assert property (
    wr && ad == iopd_pkg::ADR_B_COPY
    |=> LATCH_C_O == {$past(wd), $past(q.latch_b[7:0])}
        && q.latch_b == LATCH_C_O
        && (q.cnt_b == $past(q.cnt_b) - 16'h0001
        || $past(q.cnt_b) == 16'h0000))
    else $error("latch c copy bad");
  a_b_rdclr: assert property (
    rd && ad == iopd_pkg::ADR_B_LO_CLR && q.cnt_b != 16'h0000
    |=> !q.ifr[iopd_pkg::IFR_UF_B] && RDATA_O == $past(q.cnt_b[7:0]))
    else $error("counter b clearing read bad");
  a_a_load: assert property (
    wr && ad == iopd_pkg::ADR_A_LOAD && q.cnt_a != 16'h0000
    |=> q.cnt_a == q.latch_a && !q.ifr[iopd_pkg::IFR_UF_A] ##1
        q.cnt_a == $past(q.latch_a) - 16'h0001 || $past(q.cnt_a) == 16'h0)
    else $error("counter a load bad");
  a_a_rdkeep: assert property (
    rd && ad == iopd_pkg::ADR_A_LO && q.ifr[iopd_pkg::IFR_UF_A]
    |=> q.ifr[iopd_pkg::IFR_UF_A]) else $error("plain read cleared flag");
  a_ifr_clear: assert property (
    wr && ad == iopd_pkg::ADR_IFR_CLR
    |=> q.ifr[7:4] == ($past(q.ifr[7:4]) | $past(set_f[7:4]))
        && q.ifr[3:0] == (($past(q.ifr[3:0]) & $past(wd[3:0]))
        | $past(EDGE_FLAG_I))) else $error("flag clear bad");
  a_ext_read: assert property (
    rd && is_ext(ad)
    |=> EXT_RD_O && !RVALID_O ##1 RVALID_O && RDATA_O == $past(EXT_RDATA_I))
    else $error("external read bad");
  a_port_write: assert property (
    wr && ad == iopd_pkg::ADR_PORT_C
    |=> PORTS_O[23:16] == $past(wd) && !EXT_WR_O)
    else $error("port write bad");
endmodule

/* verif/iopd_ext_mem.sv */
`timescale 1ns/1ns
// stand-in for the external data bus, answering in the read cycle
module iopd_ext_mem (
  input wire logic EXT_RD_O,
  input wire logic [4:0] EXT_ADDR_O,
  output logic [7:0] EXT_RDATA_I
);
  // outside a read the bus shows the inverse, so a late sample cannot pass
  always_comb begin
    EXT_RDATA_I = {3'h5, EXT_ADDR_O};
    if (!EXT_RD_O) begin
      EXT_RDATA_I = ~EXT_RDATA_I;
    end
  end
endmodule

/* verif/io_page_register_decode_test.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module io_page_register_decode_test;
  logic CLK_I, SYS_RST_I, RVALID_O, EXT_RD_O, EXT_WR_O;
  logic SER_RX_STB_I, SER_TX_DONE_I, SER_TX_LOAD_O;
  iopd_pkg::iopd_req_s BUS_REQ_I;
  logic [7:0] RDATA_O, EXT_WDATA_O, EXT_RDATA_I, SER_RX_DATA_I, SER_TXD_O;
  logic [7:0] MODE_O, SCTL_O, IER_O, IFR_O, v;
  logic [4:0] EXT_ADDR_O, b;
  logic [3:0] EDGE_FLAG_I;
  logic [31:0] PORTS_O;
  logic [15:0] LATCH_C_O;
  int err_total = 0;
  int num_checks = 0;
  // rows: address, written byte, byte read back
  logic [4:0] ra[9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h14, 5'h15, 5'h12,
    5'h16, 5'h10};
  logic [7:0] rw[9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'ha5, 8'h5a, 8'hc3,
    8'hff, 8'hff};
  logic [7:0] rx[9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'ha5, 8'h5a, 8'hc3,
    8'hb0, 8'hff};

  iopd_io_page u_dut (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .BUS_REQ_I(BUS_REQ_I),
    .RDATA_O(RDATA_O),
    .RVALID_O(RVALID_O),
    .EXT_RD_O(EXT_RD_O),
    .EXT_WR_O(EXT_WR_O),
    .EXT_ADDR_O(EXT_ADDR_O),
    .EXT_WDATA_O(EXT_WDATA_O),
    .EXT_RDATA_I(EXT_RDATA_I),
    .EDGE_FLAG_I(EDGE_FLAG_I),
    .SER_RX_STB_I(SER_RX_STB_I),
    .SER_RX_DATA_I(SER_RX_DATA_I),
    .SER_TX_DONE_I(SER_TX_DONE_I),
    .SER_TXD_O(SER_TXD_O),
    .SER_TX_LOAD_O(SER_TX_LOAD_O),
    .PORTS_O(PORTS_O),
    .MODE_O(MODE_O),
    .SCTL_O(SCTL_O),
    .IER_O(IER_O),
    .IFR_O(IFR_O),
    .LATCH_C_O(LATCH_C_O)
  );
  iopd_ext_mem u_ext (
    .EXT_RD_O(EXT_RD_O),
    .EXT_ADDR_O(EXT_ADDR_O),
    .EXT_RDATA_I(EXT_RDATA_I)
  );

  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end

  // one idle cycle after every request keeps external reads apart
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    BUS_REQ_I <= {2'b01, a, d};
    @(posedge CLK_I);
    BUS_REQ_I <= '0;
    // the write lands in this edge's update region; look half a cycle on
    @(negedge CLK_I);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge CLK_I);
    BUS_REQ_I <= {2'b10, a, 8'h00};
    @(posedge CLK_I);
    BUS_REQ_I <= '0;
    d = 8'hxx;
    for (int k = 0; k < 4; k++) begin
      @(negedge CLK_I);
      if (RVALID_O === 1'b1) begin
        d = RDATA_O;
        break;
      end
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge CLK_I);
    err_total++;
    final_report();
  end

  initial begin
    SYS_RST_I = 1'b1;
    BUS_REQ_I = '0;
    EDGE_FLAG_I = 4'h0;
    SER_RX_STB_I = 1'b0;
    SER_RX_DATA_I = 8'h00;
    SER_TX_DONE_I = 1'b0;
    repeat (4) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    rdchk(5'h16, 8'h80);
    `CHK(PORTS_O, 32'h0)
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rdchk(ra[i], rx[i]);
    end
    `CHK(PORTS_O, 32'h44332211)
    `CHK({MODE_O, SCTL_O, IER_O}, 24'ha55ac3)
    wr(5'h17, 8'h5a);
    `CHK(SER_TXD_O, 8'h5a)
    `CHK(SER_TX_LOAD_O, 1'b1)
    @(posedge CLK_I);
    SER_RX_STB_I <= 1'b1;
    SER_RX_DATA_I <= 8'h3c;
    @(posedge CLK_I);
    SER_RX_STB_I <= 1'b0;
    rdchk(5'h16, 8'h31);
    rdchk(5'h17, 8'h3c);
    @(posedge CLK_I);
    SER_TX_DONE_I <= 1'b1;
    EDGE_FLAG_I <= 4'hf;
    @(posedge CLK_I);
    SER_TX_DONE_I <= 1'b0;
    EDGE_FLAG_I <= 4'h0;
    rdchk(5'h16, 8'hb0);
    wr(5'h10, 8'hfa);
    `CHK(IFR_O[3:0], 4'ha)
    wr(5'h10, 8'h00);
    `CHK({IFR_O[7], IFR_O[3:0]}, 5'h10)
    rdchk(5'h05, 8'ha5);
    wr(5'h0a, 8'h66);
    `CHK({EXT_ADDR_O, EXT_WDATA_O}, 13'h0a66)
    `CHK(EXT_WR_O, 1'b1)
    // A then B; a short load with a long latch behind it underflows once
    for (int i = 0; i < 2; i++) begin
      b = (i == 1) ? 5'h1c : 5'h18;
      wr(b, 8'hff);
      wr(b + 5'h2, 8'hff);
      @(negedge CLK_I);
      `CHK(IFR_O[4+i], 1'b0)
      rdchk(b + 5'h2, 8'hff);
      wr(b, 8'h05);
      wr(b + 5'h2, 8'h00);
      wr(b + 5'h1, 8'hff);
      if (i == 1) `CHK(LATCH_C_O, 16'hff05)
      repeat (10) @(posedge CLK_I);
      @(negedge CLK_I);
      `CHK(IFR_O[4+i], 1'b1)
      rd(b + 5'h3, v);
      `CHK(IFR_O[4+i], 1'b1)
      rd(b + 5'h1, v);
      `CHK(IFR_O[4+i], 1'b0)
    end
    // reset in mid-run must bring back the reset values
    @(posedge CLK_I);
    SYS_RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    @(negedge CLK_I);
    `CHK({PORTS_O, LATCH_C_O, IFR_O, MODE_O}, 64'h0)
    rdchk(5'h16, 8'h80);
    final_report();
  end
endmodule
